//--- design/icir_params.svh
// offsets, field positions, reset values and the summary of operation
//
// Summary of operation
// RULE1: tx context completing output-last descriptor with irq bits raises its event
// RULE2: rx context completing any input descriptor with irq bits raises its event
// RULE3: event bits set on rising edge of context interrupt, then stay set
// RULE4: write to event set address sets every bit written as one
// RULE5: event bits cleared only by writing one at clear address
// RULE6: bits 31:8 of all event and mask registers read as zero
// RULE7: tx event bit n shows tx context n caused summary interrupt
// RULE8: rx event bit n shows rx context n caused summary interrupt
// RULE9: tx events drive main event bit 6; software then reads tx events
// RULE10: rx events drive main event bit 7; software then reads rx events
// RULE11: mask read at set or clear address returns mask contents
// RULE12: tx mask enables tx summary per context, aligned to event bits
// RULE13: rx mask enables rx summary per context, aligned to event bits
// RULE14: tx event set at 90h, clear at 94h
// RULE15: read at tx event clear address returns event anded with mask
// RULE16: tx mask set at 98h, clear at 9Ch
// RULE17: rx event set at A0h, clear at A4h, resets to zero
// RULE18: rx mask set at A8h, clear at ACh
// RULE19: summary bit is live or over contexts of event and mask
// RULE20: external interrupt only while global gate bit is set
// RULE21: zero data bits leave event and mask bits unchanged
// RULE22: hardware set beats software clear in the same cycle
`ifndef ICIR_PARAMS_SVH
`define ICIR_PARAMS_SVH

`define ICIR_TX_EVENT_SET   8'h90
`define ICIR_TX_EVENT_CLEAR 8'h94
`define ICIR_TX_ENABLE_SET  8'h98
`define ICIR_TX_ENABLE_CLR  8'h9C
`define ICIR_RX_EVENT_SET   8'hA0
`define ICIR_RX_EVENT_CLEAR 8'hA4
`define ICIR_RX_ENABLE_SET  8'hA8
`define ICIR_RX_ENABLE_CLR  8'hAC
`define ICIR_TX_SUMMARY_BIT 6
`define ICIR_RX_SUMMARY_BIT 7
`define ICIR_CTX_RESET      8'h00

`endif

//--- design/icir_pkg.sv
// types shared by the isochronous context interrupt registers
package icir_pkg;

    typedef logic [7:0] icir_ctx_type;

    typedef struct packed {
        icir_ctx_type tx_event_value;
        icir_ctx_type tx_enable_value;
        icir_ctx_type rx_event_value;
        icir_ctx_type rx_enable_value;
        icir_ctx_type tx_done_prev;
        icir_ctx_type rx_done_prev;
        logic [31:0]  rd_data;
    } icir_state_type;

endpackage

//--- design/icir_regs.sv
// isochronous transmit and receive context interrupt event and mask registers
`timescale 1ns/10ps
`include "icir_params.svh"

module icir_regs #(
    parameter int CTX = 8
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // register port
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wr_data,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    output logic      [31:0] rd_data,
    // context completion signals from the dma engines
    input  wire logic [7:0]  tx_ctx_done,
    input  wire logic [7:0]  rx_ctx_done,
    // global gate from the main mask register
    input  wire logic        global_irq_gate,
    // summary and external interrupt
    output logic             tx_summary_interrupt,
    output logic             rx_summary_interrupt,
    output logic [31:0]      main_event_bits,
    output logic             irq_out
);

    // ========================================================
    // state and next state
    // ========================================================
    icir_pkg::icir_state_type state;
    icir_pkg::icir_state_type next_state;

    // one bit per context: edge set wins over a clear write
    function automatic icir_pkg::icir_ctx_type upd_event(
        input icir_pkg::icir_ctx_type cur,
        input icir_pkg::icir_ctx_type edge_set,
        input icir_pkg::icir_ctx_type sw_set,
        input icir_pkg::icir_ctx_type sw_clr
    );
        upd_event = (cur & ~sw_clr) | sw_set | edge_set; // [RULE22] [RULE21]
    endfunction

    // widen a context byte to a bus word, upper bits zero
    function automatic logic [31:0] widen(input icir_pkg::icir_ctx_type v);
        widen = {24'h000000, v}; // [RULE6]
    endfunction

    logic [7:0] tx_edge;
    logic [7:0] rx_edge;
    logic [7:0] wr_byte;

    // ========================================================
    // next state logic
    // ========================================================
    always_comb begin
        next_state = state;
        wr_byte = wr_data[7:0];
        // only the rising edge sets, a held level does not re-set
        tx_edge = tx_ctx_done & ~state.tx_done_prev; // [RULE3] [RULE1]
        rx_edge = rx_ctx_done & ~state.rx_done_prev; // [RULE3] [RULE2]
        next_state.tx_done_prev = tx_ctx_done;
        next_state.rx_done_prev = rx_ctx_done;
        // hardware never clears; only a clear-address write does [RULE5]
        next_state.tx_event_value = upd_event(state.tx_event_value, tx_edge,
            (wr_en && addr == `ICIR_TX_EVENT_SET)   ? wr_byte : 8'h00,
            (wr_en && addr == `ICIR_TX_EVENT_CLEAR) ? wr_byte : 8'h00);
        next_state.rx_event_value = upd_event(state.rx_event_value, rx_edge,
            (wr_en && addr == `ICIR_RX_EVENT_SET)   ? wr_byte : 8'h00,
            (wr_en && addr == `ICIR_RX_EVENT_CLEAR) ? wr_byte : 8'h00);
        // write-one-to-set and write-one-to-clear on the masks
        if (wr_en && addr == `ICIR_TX_ENABLE_SET) begin // [RULE16] [RULE4]
            next_state.tx_enable_value = state.tx_enable_value | wr_byte;
        end else if (wr_en && addr == `ICIR_TX_ENABLE_CLR) begin // [RULE16]
            next_state.tx_enable_value = state.tx_enable_value & ~wr_byte;
        end else if (wr_en && addr == `ICIR_RX_ENABLE_SET) begin // [RULE18]
            next_state.rx_enable_value = state.rx_enable_value | wr_byte;
        end else if (wr_en && addr == `ICIR_RX_ENABLE_CLR) begin // [RULE18]
            next_state.rx_enable_value = state.rx_enable_value & ~wr_byte;
        end
        // read decode; unmapped offsets read as zero
        next_state.rd_data = 32'h00000000;
        if (!rd_en) begin
            next_state.rd_data = 32'h00000000;
        end else if (addr == `ICIR_TX_EVENT_SET) begin // [RULE14] [RULE7]
            next_state.rd_data = widen(state.tx_event_value);
        end else if (addr == `ICIR_TX_EVENT_CLEAR) begin // [RULE15]
            next_state.rd_data = widen(state.tx_event_value
                                       & state.tx_enable_value);
        end else if (addr == `ICIR_TX_ENABLE_SET ||
                     addr == `ICIR_TX_ENABLE_CLR) begin // [RULE11]
            next_state.rd_data = widen(state.tx_enable_value);
        end else if (addr == `ICIR_RX_EVENT_SET ||
                     addr == `ICIR_RX_EVENT_CLEAR) begin // [RULE17] [RULE8]
            next_state.rd_data = widen(state.rx_event_value);
        end else if (addr == `ICIR_RX_ENABLE_SET ||
                     addr == `ICIR_RX_ENABLE_CLR) begin // [RULE11]
            next_state.rd_data = widen(state.rx_enable_value);
        end
    end

    // ========================================================
    // state register
    // ========================================================
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            // masks reset to zero too, so nothing fires before setup
            state.tx_event_value  <= `ICIR_CTX_RESET;
            state.tx_enable_value <= `ICIR_CTX_RESET;
            state.rx_event_value  <= `ICIR_CTX_RESET; // [RULE17]
            state.rx_enable_value <= `ICIR_CTX_RESET;
            state.tx_done_prev    <= `ICIR_CTX_RESET;
            state.rx_done_prev    <= `ICIR_CTX_RESET;
            state.rd_data         <= 32'h00000000;
        end else begin
            state <= next_state;
        end
    end

    // ========================================================
    // summary outputs, live and unlatched
    // ========================================================
    assign rd_data = state.rd_data;
    assign tx_summary_interrupt =
        |(state.tx_event_value & state.tx_enable_value); // [RULE19] [RULE12]
    assign rx_summary_interrupt =
        |(state.rx_event_value & state.rx_enable_value); // [RULE19] [RULE13]
    // main event bit positions for the summaries
    always_comb begin
        main_event_bits = 32'h00000000;
        main_event_bits[`ICIR_TX_SUMMARY_BIT] = tx_summary_interrupt; // [RULE9]
        main_event_bits[`ICIR_RX_SUMMARY_BIT] = rx_summary_interrupt; // [RULE10]
    end
    // gate blocks irq_out regardless of context masks; summaries and main_event_bits stay ungated
    assign irq_out = global_irq_gate &&
        (tx_summary_interrupt || rx_summary_interrupt); // [RULE20]

    // ========================================================
    // assertions
    // ========================================================
    AST_TX_EDGE_SETS: assert property (@(posedge clk) disable iff (!rst_n) // [RULE3]
        (tx_ctx_done[0] && !state.tx_done_prev[0]) |=> state.tx_event_value[0])
        else $error("tx edge did not set event");
    AST_RX_EDGE_SETS: assert property (@(posedge clk) disable iff (!rst_n) // [RULE2]
        (rx_ctx_done[3] && !state.rx_done_prev[3]) |=> state.rx_event_value[3])
        else $error("rx edge did not set event");
    AST_STICKY: assert property (@(posedge clk) disable iff (!rst_n) // [RULE5]
        (state.tx_event_value[2] &&
         !(wr_en && addr == `ICIR_TX_EVENT_CLEAR && wr_data[2]))
        |=> state.tx_event_value[2])
        else $error("tx event cleared without clear write");
    AST_SET_WRITE: assert property (@(posedge clk) disable iff (!rst_n) // [RULE4]
        (wr_en && addr == `ICIR_RX_EVENT_SET && wr_data[5])
        |=> state.rx_event_value[5])
        else $error("set write failed");
    AST_SET_WINS: assert property (@(posedge clk) disable iff (!rst_n) // [RULE22]
        (rx_edge[1] && wr_en && addr == `ICIR_RX_EVENT_CLEAR)
        |=> state.rx_event_value[1])
        else $error("clear beat hardware set");
    AST_MASK_READ: assert property (@(posedge clk) disable iff (!rst_n) // [RULE11]
        (rd_en && addr == `ICIR_RX_ENABLE_CLR && !wr_en)
        |=> rd_data == {24'h000000, $past(state.rx_enable_value)})
        else $error("mask read mismatch");
    AST_RESERVED: assert property (@(posedge clk) disable iff (!rst_n) // [RULE6]
        rd_data[31:8] == 24'h000000)
        else $error("reserved bits nonzero");
    AST_SUMMARY: assert property (@(posedge clk) disable iff (!rst_n) // [RULE19]
        (state.tx_event_value[4] && state.tx_enable_value[4])
        |-> main_event_bits[6])
        else $error("tx summary missing");
    AST_GATE: assert property (@(posedge clk) disable iff (!rst_n) // [RULE20]
        !global_irq_gate |-> !irq_out)
        else $error("irq without gate");

endmodule

//--- testbench/tb_top.sv
// self-checking testbench for the isochronous context interrupt registers
`timescale 1ns/10ps
`include "icir_params.svh"

module tb_top;
    // ==========================================
    // clock, reset and design ports
    logic        clk;
    logic        rst_n;
    logic [7:0]  addr;
    logic [31:0] wr_data;
    logic        wr_en;
    logic        rd_en;
    logic [31:0] rd_data;
    logic [7:0]  tx_ctx_done;
    logic [7:0]  rx_ctx_done;
    logic        global_irq_gate;
    logic        tx_sum;
    logic        rx_sum;
    logic [31:0] main_event_bits;
    logic        irq_out;
    int          mismatches;
    int          n_checks;
    int          cycles = 0;

    icir_regs #(.CTX(8)) u_dut (.clk(clk), .rst_n(rst_n), .addr(addr),
        .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .tx_ctx_done(tx_ctx_done), .rx_ctx_done(rx_ctx_done),
        .global_irq_gate(global_irq_gate), .tx_summary_interrupt(tx_sum),
        .rx_summary_interrupt(rx_sum), .main_event_bits(main_event_bits),
        .irq_out(irq_out));

    // ==========================================
    // shared tasks
    task automatic check(input string what, input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr    <= a;
        wr_data <= d;
        wr_en   <= 1'b1;
        @(posedge clk);
        wr_en   <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 check($sformatf("read %h", a), rd_data, exp);
    endtask
    // summaries are live, so they are judged a step after the edge
    task automatic sum_chk(input logic t, r, g);
        #1 check("main", main_event_bits, {24'h0, r, t, 6'h0});
        check("irq", {29'h0, tx_sum, rx_sum, irq_out}, {29'h0, t, r, g&(t|r)});
    endtask

    // ==========================================
    // scenarios
    task automatic test_tx_sw();
        wr(`ICIR_TX_EVENT_SET, 32'hFFFF_FFA5);
        rd_chk(`ICIR_TX_EVENT_SET, 32'h0000_00A5);
        sum_chk(1'b0, 1'b0, 1'b1);
        wr(`ICIR_TX_ENABLE_SET, 32'h0000_000F);
        rd_chk(`ICIR_TX_ENABLE_CLR, 32'h0000_000F);
        sum_chk(1'b1, 1'b0, 1'b1);
        rd_chk(`ICIR_TX_EVENT_CLEAR, 32'h0000_0005);
        wr(`ICIR_TX_EVENT_CLEAR, 32'h0000_0005);
        rd_chk(`ICIR_TX_EVENT_SET, 32'h0000_00A0);
        sum_chk(1'b0, 1'b0, 1'b1);
        wr(`ICIR_TX_ENABLE_CLR, 32'h0000_0003);
        rd_chk(`ICIR_TX_ENABLE_SET, 32'h0000_000C);
        wr(8'h80, 32'hFFFF_FFFF);
        rd_chk(8'h80, 32'h0);
        wr(`ICIR_TX_EVENT_CLEAR, 32'h0000_00FF);
    endtask
    // each context in turn; the held level must not set again after a clear
    task automatic test_hw_edge();
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            tx_ctx_done <= 8'h01 << i;
            rx_ctx_done <= 8'h80 >> i;
            rd_chk(`ICIR_TX_EVENT_SET, 32'h1 << i);
            rd_chk(`ICIR_RX_EVENT_CLEAR, 32'h80 >> i);
            wr(`ICIR_TX_EVENT_CLEAR, 32'h1 << i);
            wr(`ICIR_RX_EVENT_CLEAR, 32'h80 >> i);
            rd_chk(`ICIR_TX_EVENT_SET, 32'h0);
            rd_chk(`ICIR_RX_EVENT_SET, 32'h0);
            @(posedge clk);
            tx_ctx_done <= 8'h00;
            rx_ctx_done <= 8'h00;
        end
    endtask
    task automatic test_rx_gate();
        wr(`ICIR_RX_ENABLE_SET, 32'h0000_0081);
        wr(`ICIR_RX_EVENT_SET, 32'h0000_0001);
        rd_chk(`ICIR_RX_ENABLE_CLR, 32'h0000_0081);
        sum_chk(1'b0, 1'b1, 1'b1);
        @(posedge clk);
        global_irq_gate <= 1'b0;
        sum_chk(1'b0, 1'b1, 1'b0);
        @(posedge clk);
        global_irq_gate <= 1'b1;
        // a rising edge and a clear write are sampled at the same edge
        @(posedge clk);
        rx_ctx_done <= 8'h01;
        addr        <= `ICIR_RX_EVENT_CLEAR;
        wr_data     <= 32'h0000_0001;
        wr_en       <= 1'b1;
        @(posedge clk);
        wr_en       <= 1'b0;
        rx_ctx_done <= 8'h00;
        rd_chk(`ICIR_RX_EVENT_SET, 32'h0000_0001);
        wr(`ICIR_RX_ENABLE_CLR, 32'h0000_0001);
        rd_chk(`ICIR_RX_ENABLE_SET, 32'h0000_0080);
    endtask

    // ==========================================
    // clock, watchdog and closing report
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            mismatches++;
            results();
        end
    end
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        {rst_n, addr, wr_data, wr_en, rd_en} = '0;
        {tx_ctx_done, rx_ctx_done, mismatches, n_checks} = '0;
        global_irq_gate = 1'b1;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            rd_chk(8'h90 + 8'(i * 4), 32'h0);
        end
        test_tx_sw();
        test_hw_edge();
        test_rx_gate();
        results();
    end
endmodule
